// ===== core/plfl_fault_hist.sv
`timescale 1ns/1ps
module plfl_fault_hist (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // History port.
    plfl_hist_if.owner hist
);
    import plfl_pkg::*;

    // These flops stand in for the non-volatile store, so reset here models a fresh store only.
    plfl_entry_type slot [PLFL_SLOTS];
    logic [3:0] rd_index;

    assign rd_index = (hist.sel >= 4'h1 && hist.sel <= 4'h9) ? 4'(hist.sel - 4'h1) : 4'h0;
    assign hist.rd_entry = slot[rd_index];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < PLFL_SLOTS; i++) begin
                slot[i] <= PLFL_ENTRY_RESET;
            end
        end else if (hist.push) begin
            for (int i = PLFL_SLOTS - 1; i > 0; i--) begin
                slot[i] <= slot[i-1];
            end
            slot[0] <= hist.entry;
        end
    end
endmodule // plfl_fault_hist

// ===== core/plfl_hist_if.sv
`timescale 1ns/1ps
interface plfl_hist_if;
    import plfl_pkg::*;
    logic push;
    plfl_entry_type entry;
    logic [3:0] sel;
    plfl_entry_type rd_entry;
    modport owner (input push, input entry, input sel, output rd_entry);
    modport user (output push, output entry, output sel, input rd_entry);
endinterface

// ===== core/plfl_pkg.sv
package plfl_pkg;
    localparam int PLFL_DIGITS = 4;
    localparam int PLFL_SLOTS = 9;
    localparam int PLFL_FAULT_W = 8;
    localparam int PLFL_MEAS_W = 16;
    localparam int PLFL_CODE_W = 16;
    localparam logic [7:0] PLFL_EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [PLFL_CODE_W-1:0] PLFL_CODE_RESET = 16'h0000;
    localparam logic [3:0] PLFL_DIGIT_MAX = 4'h9;
    localparam logic [1:0] PLFL_LAST_DIGIT = 2'h3;
    localparam logic [1:0] PLFL_VIEW_LAST = 2'h3;

    typedef enum logic [1:0] {
        PLFL_SHOW_VALUE,
        PLFL_SHOW_OFF,
        PLFL_SHOW_ON
    } plfl_show_type;

    typedef struct packed {
        logic [PLFL_FAULT_W-1:0] fault_num;
        logic [PLFL_MEAS_W-1:0] condition;
        logic [PLFL_MEAS_W-1:0] current;
        logic [PLFL_MEAS_W-1:0] voltage;
        logic [PLFL_MEAS_W-1:0] frequency;
    } plfl_entry_type;

    localparam plfl_entry_type PLFL_ENTRY_RESET = '0;
endpackage

// ===== core/plfl_top.sv
`timescale 1ns/1ps
module plfl_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Keypad, already debounced to single-cycle pulses on clk, except the history key and slot select, which are held levels.
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_enter,
    input wire logic key_escape,
    input wire logic lock_code_menu_item,
    input wire logic fault_history_parameter_entry_key,
    input wire logic [3:0] fault_slot_sel,
    // Parameter change requests.
    input wire logic edit_active,
    input wire logic bus_write,
    // Fault capture.
    input wire logic fault_event,
    input wire logic [plfl_pkg::PLFL_FAULT_W-1:0] fault_num,
    input wire logic [plfl_pkg::PLFL_MEAS_W-1:0] meas_condition,
    input wire logic [plfl_pkg::PLFL_MEAS_W-1:0] meas_current,
    input wire logic [plfl_pkg::PLFL_MEAS_W-1:0] meas_voltage,
    input wire logic [plfl_pkg::PLFL_MEAS_W-1:0] meas_frequency,
    // Lock status and answers.
    output logic locked,
    output logic edit_inc,
    output logic edit_dec,
    output logic bus_write_ok,
    output logic bus_exception,
    output logic [7:0] bus_exc_code,
    // Display.
    output plfl_pkg::plfl_show_type lock_show,
    output logic [3:0] entry_digit,
    output logic [1:0] entry_pos,
    output logic [plfl_pkg::PLFL_FAULT_W-1:0] hist_fault_num,
    output logic [1:0] hist_view,
    output logic [plfl_pkg::PLFL_MEAS_W-1:0] hist_value
);
    import plfl_pkg::*;

    plfl_hist_if hist ();

    logic [PLFL_CODE_W-1:0] lock_code;
    logic [PLFL_CODE_W-1:0] compose;
    logic entering;
    logic next_locked;
    logic [PLFL_CODE_W-1:0] next_lock_code;
    logic [PLFL_CODE_W-1:0] next_compose;
    logic [3:0] next_digit;
    logic last_enter;
    logic [PLFL_CODE_W-1:0] composed_full;
    plfl_show_type next_show;

    assign composed_full = {compose[PLFL_CODE_W-5:0], entry_digit};
    assign last_enter = entering && key_enter && (entry_pos == PLFL_LAST_DIGIT);

    assign next_digit = key_up ? ((entry_digit == PLFL_DIGIT_MAX) ? 4'h0 : 4'(entry_digit + 4'h1)) :
                        key_down ? ((entry_digit == 4'h0) ? PLFL_DIGIT_MAX : 4'(entry_digit - 4'h1)) :
                        entry_digit;

    assign next_locked = !last_enter ? locked :
                         !locked ? 1'b1 :
                         (composed_full == lock_code) ? 1'b0 : 1'b1;
    assign next_lock_code = (last_enter && !locked) ? composed_full : lock_code;
    assign next_compose = key_enter ? composed_full : compose;

    assign next_show = (lock_code_menu_item && !entering) ? (locked ? PLFL_SHOW_ON : PLFL_SHOW_OFF) :
                       (entering && !last_enter && !key_escape) ? PLFL_SHOW_VALUE : lock_show;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            locked <= 1'b0;
            lock_code <= PLFL_CODE_RESET;
        end else begin
            locked <= next_locked;
            lock_code <= next_lock_code;
        end
    end

    // Code entry walks four digits, most significant first.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            entering <= 1'b0;
            entry_pos <= 2'h0;
            entry_digit <= 4'h0;
            compose <= PLFL_CODE_RESET;
            lock_show <= PLFL_SHOW_OFF;
        end else begin
            lock_show <= next_show;
            if (!entering) begin
                if (lock_code_menu_item) begin
                    entering <= 1'b1;
                    entry_pos <= 2'h0;
                    entry_digit <= 4'h0;
                    compose <= PLFL_CODE_RESET;
                end
            end else if (key_escape || last_enter) begin
                entering <= 1'b0;
            end else if (key_enter) begin
                compose <= next_compose;
                entry_pos <= 2'(entry_pos + 2'h1);
                entry_digit <= 4'h0;
            end else begin
                entry_digit <= next_digit;
            end
        end
    end

    logic edit_ok;
    assign edit_ok = edit_active && !locked && !entering;

    logic bus_refuse;
    assign bus_refuse = bus_write && locked;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            edit_inc <= 1'b0;
            edit_dec <= 1'b0;
            bus_write_ok <= 1'b0;
            bus_exception <= 1'b0;
            bus_exc_code <= 8'h00;
        end else begin
            edit_inc <= edit_ok && key_up;
            edit_dec <= edit_ok && key_down;
            bus_write_ok <= bus_write && !locked;
            bus_exception <= bus_refuse;
            bus_exc_code <= bus_refuse ? PLFL_EXC_ILLEGAL_VALUE : 8'h00;
        end
    end

    // capture line conditions with the fault
    assign hist.push = fault_event;
    assign hist.entry = '{fault_num: fault_num, condition: meas_condition, current: meas_current,
                          voltage: meas_voltage, frequency: meas_frequency};
    assign hist.sel = fault_slot_sel;

    plfl_fault_hist u_hist (
        .clk(clk),
        .rstn(rstn),
        .hist(hist.owner)
    );

    logic [PLFL_MEAS_W-1:0] view_value;
    assign view_value = (hist_view == 2'h0) ? hist.rd_entry.condition :
                        (hist_view == 2'h1) ? hist.rd_entry.current :
                        (hist_view == 2'h2) ? hist.rd_entry.voltage :
                        hist.rd_entry.frequency;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hist_view <= 2'h0;
            hist_fault_num <= '0;
            hist_value <= '0;
        end else begin
            hist_fault_num <= hist.rd_entry.fault_num;
            hist_value <= view_value;
            if (!fault_history_parameter_entry_key) begin
                hist_view <= 2'h0;
            end else if (key_enter) begin
                hist_view <= (hist_view == PLFL_VIEW_LAST) ? 2'h0 : 2'(hist_view + 2'h1);
            end
        end
    end
endmodule // plfl_top

// ===== verif/plfl_chk.sv
`timescale 1ns/1ps
module plfl_chk (
    // Requests.
    input wire logic clk,
    input wire logic rstn,
    input wire logic key_enter,
    input wire logic lock_code_menu_item,
    input wire logic fault_history_parameter_entry_key,
    input wire logic [3:0] fault_slot_sel,
    input wire logic bus_write,
    input wire logic fault_event,
    input wire logic [7:0] fault_num,
    // Answers.
    input wire logic locked,
    input wire logic edit_inc,
    input wire logic edit_dec,
    input wire logic bus_write_ok,
    input wire logic bus_exception,
    input wire logic [7:0] bus_exc_code,
    input wire plfl_pkg::plfl_show_type lock_show,
    input wire logic [7:0] hist_fault_num,
    input wire logic [1:0] hist_view
);
    import plfl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_fault_seen;
        fault_event && fault_slot_sel == 4'h1 ##1 fault_slot_sel == 4'h1 && !fault_event;
    endsequence
    AST_BUS_OK: assert property (bus_write && !locked |=> bus_write_ok && !bus_exception)
        else $error("unlocked write refused");
    AST_BUS_EXC: assert property (bus_write && locked |=> bus_exception && bus_exc_code == 8'h03)
        else $error("locked write not refused");
    AST_EXC_IDLE: assert property (!bus_exception |-> bus_exc_code == 8'h00)
        else $error("stray exception code");
    AST_EDIT_LOCK: assert property (locked |=> !edit_inc && !edit_dec)
        else $error("edit passed while locked");
    AST_LOCK_STEP: assert property ($changed(locked) |-> $past(key_enter))
        else $error("lock moved without enter");
    AST_SHOW_OFF: assert property (lock_code_menu_item && !locked |=> lock_show == PLFL_SHOW_OFF)
        else $error("unarmed item not off");
    AST_SHOW_ON: assert property (lock_code_menu_item && locked |=> lock_show == PLFL_SHOW_ON)
        else $error("armed item not on");
    AST_SLOT1: assert property (s_fault_seen |=> hist_fault_num == $past(fault_num, 2))
        else $error("newest slot wrong");
    AST_VIEW: assert property (key_enter && fault_history_parameter_entry_key ##1 fault_history_parameter_entry_key |->
        hist_view == $past(hist_view) + 2'h1)
        else $error("view did not advance");
endmodule // plfl_chk
bind plfl_top plfl_chk plfl_chk_inst (.clk, .rstn, .key_enter, .lock_code_menu_item, .fault_history_parameter_entry_key,
    .fault_slot_sel, .bus_write, .fault_event, .fault_num, .locked, .edit_inc, .edit_dec, .bus_write_ok,
    .bus_exception, .bus_exc_code, .lock_show, .hist_fault_num, .hist_view);

// ===== verif/plfl_operator.sv
`timescale 1ns/1ps
module plfl_operator (
    // Clock.
    input wire logic clk,
    // Keypad and bus master.
    output logic key_up,
    output logic key_down,
    output logic key_enter,
    output logic key_escape,
    output logic lock_code_menu_item,
    output logic bus_write,
    output logic edit_active
);
    logic [5:0] k = 6'h00;
    assign {bus_write, lock_code_menu_item, key_escape, key_enter, key_down, key_up} = k;
    initial edit_active = 1'b0;
    // Keys are one-cycle pulses, so a gap cycle keeps two taps apart.
    task automatic tap(input int i, input logic e);
        @(posedge clk);
        k <= 6'h01 << i;
        edit_active <= e;
        @(posedge clk);
        k <= 6'h00;
        edit_active <= 1'b0;
    endtask
    task automatic enter_code(input logic [15:0] c);
        tap(4, 1'b0);
        for (int d = 3; d >= 0; d--) begin
            repeat (c[d*4 +: 4]) tap(0, 1'b0);
            tap(2, 1'b0);
        end
    endtask
endmodule // plfl_operator

// ===== verif/test_parameter_lock_and_fault_log.sv
`timescale 1ns/1ps
module test_parameter_lock_and_fault_log;
    import plfl_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic fault_history_parameter_entry_key = 1'b0;
    logic fault_event = 1'b0;
    logic [3:0] fault_slot_sel = 4'h1;
    logic [7:0] fault_num = 8'h00;
    logic [15:0] meas_condition = 16'h0000, meas_current = 16'h0000, meas_voltage = 16'h0000;
    logic [15:0] meas_frequency = 16'h0000;
    wire key_up, key_down, key_enter, key_escape, lock_code_menu_item, bus_write, edit_active;
    wire locked, edit_inc, edit_dec, bus_write_ok, bus_exception;
    wire [7:0] bus_exc_code, hist_fault_num;
    wire plfl_show_type lock_show;
    wire [1:0] hist_view;
    wire [3:0] entry_digit;
    wire [1:0] entry_pos;
    wire [15:0] hist_value;
    int n_mismatch = 0;
    int checks = 0;
    plfl_operator plfl_operator_inst (.clk, .key_up, .key_down, .key_enter, .key_escape,
        .lock_code_menu_item, .bus_write, .edit_active);
    plfl_top plfl_top_inst (.clk, .rstn, .key_up, .key_down, .key_enter, .key_escape, .lock_code_menu_item,
        .fault_history_parameter_entry_key, .fault_slot_sel, .edit_active, .bus_write, .fault_event, .fault_num,
        .meas_condition, .meas_current, .meas_voltage, .meas_frequency, .locked, .edit_inc, .edit_dec,
        .bus_write_ok, .bus_exception, .bus_exc_code, .lock_show, .entry_digit, .entry_pos,
        .hist_fault_num, .hist_view, .hist_value);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic op(input int i, input logic e);
        plfl_operator_inst.tap(i, e);
        #1;
    endtask
    task automatic code(input logic [15:0] c);
        plfl_operator_inst.enter_code(c);
        @(posedge clk);
        #1;
    endtask
    task automatic t_unlocked();
        op(4, 0);
        chk(lock_show, PLFL_SHOW_OFF);
        op(0, 0);
        chk({entry_pos, entry_digit}, 6'h01);
        op(2, 0);
        op(1, 0);
        chk({entry_pos, entry_digit}, 6'h19);
        op(3, 0);
        chk(locked, 1'b0);
        op(0, 1);
        chk(edit_inc, 1'b1);
        op(1, 1);
        chk(edit_dec, 1'b1);
        op(5, 0);
        chk(bus_write_ok, 1'b1);
        $display("unlocked test done");
    endtask
    task automatic t_locked();
        code(16'h9081);
        chk(locked, 1'b1);
        op(4, 0);
        chk(lock_show, PLFL_SHOW_ON);
        op(3, 0);
        op(0, 1);
        chk(edit_inc, 1'b0);
        op(5, 0);
        chk({bus_write_ok, bus_exception, bus_exc_code}, 10'h103);
        code(16'h9080);
        chk(locked, 1'b1);
        code(16'h9081);
        chk(locked, 1'b0);
        repeat (20) @(posedge clk);
        op(5, 0);
        chk({locked, bus_write_ok}, 2'h1);
        $display("locked test done");
    endtask
    task automatic t_faults();
        @(posedge clk) fault_history_parameter_entry_key <= 1'b1;
        for (int n = 1; n <= 10; n++) begin
            @(posedge clk);
            fault_event <= 1'b1;
            fault_num <= 8'(n);
            meas_condition <= {8'h01, 8'(n)};
            meas_current <= {8'h02, 8'(n)};
            meas_voltage <= {8'h03, 8'(n)};
            meas_frequency <= {8'h04, 8'(n)};
            @(posedge clk) fault_event <= 1'b0;
        end
        @(posedge clk) fault_slot_sel <= 4'h9;
        @(posedge clk) fault_slot_sel <= 4'h1;
        #1 chk(hist_fault_num, 8'h02);
        @(posedge clk);
        #1 chk(hist_fault_num, 8'h0a);
        for (int v = 0; v < 4; v++) begin
            repeat (2) @(posedge clk);
            #1 chk(hist_value, {8'(v + 1), 8'h0a});
            op(2, 0);
        end
        chk(hist_view, 2'h0);
        $display("fault log test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_unlocked();
        t_locked();
        t_faults();
        conclude();
    end
endmodule // test_parameter_lock_and_fault_log
